// ===== src/dll_switch_seq.v
/*
 * host-side sequencer that switches a ddr3 sdram between dll-on and
 * dll-off operation through self refresh and a clock change.
 * assumes the caller has idled the memory (banks precharged, odt off)
 * before pulsing start, and that a clock generator answers freq_req
 * with a freq_ack level from another domain.
 * mode register values must stay put while busy is high; odt is held
 * low for the whole run, which suits either termination setting.
 */
`default_nettype none
`include "dll_switch_regs.vh"

module dll_switch_seq (
    input wire mclk,
    input wire reset_n,
    // user side: one switch per start pulse
    input wire start,
    input wire to_dll_off,
    input wire zq_long_en,
    input wire [13:0] mr0_value,
    input wire [13:0] mr1_value,
    input wire [13:0] mr2_value,
    // clock generator handshake, then busy and done for the user
    input wire freq_ack,
    output reg freq_req,
    output reg busy,
    output reg done,
    // memory command pins
    output reg cke,
    output reg odt,
    output reg [3:0] cmd,
    output reg [2:0] ba,
    output reg [13:0] addr
);
    // sequence steps, binary coded
    localparam [3:0] S_IDLE = 4'h0;
    localparam [3:0] S_DIS = 4'h1;
    localparam [3:0] S_SRE = 4'h2;
    localparam [3:0] S_FREQ = 4'h3;
    localparam [3:0] S_SRX = 4'h4;
    localparam [3:0] S_EN = 4'h5;
    localparam [3:0] S_RST = 4'h6;
    localparam [3:0] S_MR0 = 4'h7;
    localparam [3:0] S_MR2 = 4'h8;
    localparam [3:0] S_ZQ = 4'h9;
    localparam [3:0] S_FIN = 4'ha;
    localparam [3:0] S_SRW = 4'hb;

    // wait figures in cycles; the counter reloads these directly
    localparam [15:0] W_MOD = `T_MOD_NCK; // mode write to next command
    localparam [15:0] W_MRD = `T_MRD_NCK; // mode write to mode write
    localparam [15:0] W_CKSRE = `T_CKSRE_NCK; // sr entry to clock change
    localparam [15:0] W_CKSRX = `T_CKSRX_NCK; // stable clock before sr exit
    // ns figures rounded up to whole cycles, then cut to counter width
    localparam integer XS_CK = `NS2CK(`T_XS_NS);
    localparam integer ZQ_CK = `NS2CK(`T_ZQOPER_NS);
    localparam [15:0] W_XS = XS_CK[15:0]; // sr exit to first mode write
    localparam [15:0] W_ZQ = ZQ_CK[15:0]; // long calibration time
    localparam [15:0] W_DLLK = `T_DLLK_NCK; // dll relock from reset write

    // sequencer state and wait plumbing
    reg [3:0] state_r; // sequence step
    reg off_r; // direction latched at start
    reg zq_r; // long calibration requested
    reg [15:0] dllk_r; // dll lock down-counter
    reg ld_r; // wait counter load
    reg [15:0] ldv_r; // wait counter value
    reg ack_s1_r, ack_s2_r, ack_s3_r; // freq_ack synchroniser
    reg ack_r; // filtered acknowledge
    wire wait_done; // step wait elapsed

    // a step may move on only once its wait has run out and no reload
    // is still in flight; the counter sees a load one edge late
    function step_free;
        input cnt_done; // counter at zero
        input load_pend; // load issued last edge
        begin
            step_free = cnt_done && !load_pend;
        end
    endfunction

    // one counter for all step waits, each edge counts once
    // a single shared counter: steps never overlap their waits
    wait_counter u_wait (
        .mclk(mclk),
        .reset_n(reset_n),
        .load(ld_r),
        .value(ldv_r),
        .done(wait_done)
    );

    // clock-generator acknowledge comes from another domain; three stages,
    // and a change counts only once the second and third agree, so a
    // metastable first stage never reaches the sequencer
    // limitation: a level handshake, so the generator must drop the
    // acknowledge after the request falls before it can be used again
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            ack_s1_r <= 1'b0;
            ack_s2_r <= 1'b0;
            ack_s3_r <= 1'b0;
            ack_r <= 1'b0;
        end else begin
            ack_s1_r <= freq_ack;
            ack_s2_r <= ack_s1_r;
            ack_s3_r <= ack_s2_r;
            if (ack_s2_r == ack_s3_r) begin
                ack_r <= ack_s3_r;
            end
        end
    end

    // issue an mrs in this cycle and arm the following wait
    // the counter takes the load one edge later, which the step guard covers
    task issue_mrs;
        input [2:0] sel;
        input [13:0] val;
        input [15:0] w;
        begin
            cmd <= `CMD_MRS;
            ba <= sel;
            addr <= val;
            ld_r <= 1'b1;
            ldv_r <= w;
        end
    endtask

    // main sequencer: one step per state, each command it issues arms the wait after it;
    // a step that issues a command must not also test the counter it loads
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            // cke idles high and the command bus rests on nop
            state_r <= S_IDLE;
            off_r <= 1'b0;
            zq_r <= 1'b0;
            dllk_r <= 16'h0000;
            ld_r <= 1'b0;
            ldv_r <= 16'h0000;
            freq_req <= 1'b0;
            busy <= 1'b0;
            done <= 1'b0;
            cke <= 1'b1;
            odt <= 1'b0;
            cmd <= `CMD_NOP;
            ba <= 3'h0;
            addr <= 14'h0000;
        end else begin
            // defaults: nop, no load, done is a pulse
            cmd <= `CMD_NOP;
            ld_r <= 1'b0;
            done <= 1'b0;
            // relock count runs whatever step the sequencer is in
            if (dllk_r != 16'h0000) begin
                dllk_r <= dllk_r - 16'h0001;
            end
            case (state_r)
            S_IDLE: begin
                // caller guarantees idle and odt off at start
                busy <= 1'b0;
                odt <= 1'b0;
                // start is refused by every other step
                if (start) begin
                    busy <= 1'b1;
                    off_r <= to_dll_off; // direction fixed for the whole run
                    zq_r <= zq_long_en;
                    state_r <= to_dll_off ? S_DIS : S_SRE;
                end
            end
            S_DIS: begin
                // disable the dll, then tmod before self refresh
                // only a0 is forced, the rest of mr1 is the caller's
                issue_mrs(`MR1_SEL, mr1_value | `MR1_DLL_OFF, W_MOD);
                state_r <= S_SRE;
            end
            S_SRE: begin
                // off->on enters here straight from idle, counter at zero
                if (step_free(wait_done, ld_r)) begin
                    // refresh with cke low is read as self refresh entry
                    cmd <= `CMD_REF; // self refresh entry with cke low
                    cke <= 1'b0;
                    ld_r <= 1'b1;
                    ldv_r <= W_CKSRE;
                    state_r <= S_FREQ;
                end
            end
            S_FREQ: begin
                // ask for the new clock only after tcksre in sr
                // a stale acknowledge from a past run must be gone first
                if (step_free(wait_done, ld_r) && !freq_req && !ack_r) begin
                    freq_req <= 1'b1;
                end
                // the filtered ack marks the new clock as stable
                if (freq_req && ack_r) begin
                    ld_r <= 1'b1;
                    ldv_r <= W_CKSRX;
                    state_r <= S_SRW;
                end
            end
            S_SRW: begin
                // stable clock for tcksrx, then exit self refresh
                freq_req <= 1'b0;
                if (step_free(wait_done, ld_r)) begin
                    cke <= 1'b1;
                    odt <= 1'b0;
                    ld_r <= 1'b1;
                    ldv_r <= W_XS;
                    // on->off skips the dll enable and reset writes
                    state_r <= off_r ? S_MR0 : S_EN;
                end
            end
            S_EN: begin
                // cke stays high from here to the end of the run
                if (step_free(wait_done, ld_r)) begin
                    issue_mrs(`MR1_SEL, mr1_value & `MR1_DLL_ON_MASK, W_MRD);
                    state_r <= S_RST;
                end
            end
            S_RST: begin
                // relock time runs on its own counter beside the step waits
                if (step_free(wait_done, ld_r)) begin
                    issue_mrs(`MR0_SEL, mr0_value | `MR0_DLL_RST, W_MRD);
                    dllk_r <= W_DLLK;
                    state_r <= S_MR0;
                end
            end
            S_MR0: begin
                // rewrite mr0 after txs or tmrd
                if (step_free(wait_done, ld_r)) begin
                    if (off_r) begin
                        // dll-off keeps only the one latency pair
                        issue_mrs(`MR0_SEL,
                            (mr0_value & `MR0_CL_MASK & `MR0_RST_CLR) | `MR0_CL6, W_MRD);
                    end else begin
                        // caller's own latencies, dll reset bit dropped
                        issue_mrs(`MR0_SEL, mr0_value & `MR0_RST_CLR, W_MRD);
                    end
                    state_r <= S_MR2;
                end
            end
            S_MR2: begin
                // last mode write: tmod follows before anything else
                if (step_free(wait_done, ld_r)) begin
                    if (off_r) begin
                        // write latency pinned to the dll-off pair
                        issue_mrs(`MR2_SEL,
                            (mr2_value & `MR2_CWL_MASK) | `MR2_CWL6, W_MOD);
                    end else begin
                        // caller's own write latency
                        issue_mrs(`MR2_SEL, mr2_value, W_MOD);
                    end
                    state_r <= S_ZQ;
                end
            end
            S_ZQ: begin
                // tmod from last write before zqcl or finish
                if (step_free(wait_done, ld_r)) begin
                    if (zq_r) begin
                        cmd <= `CMD_ZQCL;
                        addr <= `ZQ_LONG_ADDR; // long form of calibration
                        ld_r <= 1'b1;
                        ldv_r <= W_ZQ;
                    end
                    // without calibration the finish step sees a spent counter
                    state_r <= S_FIN;
                end
            end
            S_FIN: begin
                // ready only after tdllk and tzqoper
                // done is a one-cycle pulse and busy falls with it
                if (step_free(wait_done, ld_r) && dllk_r == 16'h0000) begin
                    done <= 1'b1;
                    busy <= 1'b0;
                    state_r <= S_IDLE;
                end
            end
            default: begin
                // unused codes fall back to idle
                state_r <= S_IDLE;
            end
            endcase
        end
    end
endmodule // dll_switch_seq
`default_nettype wire

// ===== src/dll_switch_regs.vh
/*
 * timing constants, command codes and mode register fields for the
 * dll mode switch sequencer. assumes a 100 mhz controller clock that is
 * also the memory clock in the current frequency setting.
 */
`ifndef DLL_SWITCH_REGS_VH
`define DLL_SWITCH_REGS_VH

// clock period in ps
`define CLK_PERIOD_PS 10000
// times in ns, figures chosen for this controller
`define T_MOD_NS 15
`define T_CKSRE_NS 10
`define T_CKSRX_NS 10
`define T_XS_NS 170
`define T_ZQOPER_NS 5120
// counts given in clock cycles, sized to the wait counter
`define T_MOD_NCK 16'h000c
`define T_MRD_NCK 16'h0004
`define T_DLLK_NCK 16'h0200
`define T_CKSRE_NCK 16'h0005
`define T_CKSRX_NCK 16'h0005
// rounded-up conversion of ns to cycles
`define NS2CK(ns) (((ns) * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
// counter width
`define WAIT_W 16

// command codes {cs_n, ras_n, cas_n, we_n}
`define CMD_NOP 4'h7
`define CMD_MRS 4'h0
`define CMD_REF 4'h1
`define CMD_ZQCL 4'h6

// mode register selectors on bank address
`define MR0_SEL 3'h0
`define MR1_SEL 3'h1
`define MR2_SEL 3'h2
// field positions
`define MR1_DLL_OFF_BIT 0
`define MR0_DLL_RST_BIT 8
`define ZQ_LONG_BIT 10
// cas latency 6 encodings
`define MR0_CL6 14'h0020
`define MR2_CWL6 14'h0008
`define MR0_CL_MASK 14'h3f8b
`define MR2_CWL_MASK 14'h3fc7
// single-bit opcode values and their clears
`define MR1_DLL_OFF 14'h0001
`define MR1_DLL_ON_MASK 14'h3ffe
`define MR0_DLL_RST 14'h0100
`define MR0_RST_CLR 14'h3eff
`define ZQ_LONG_ADDR 14'h0400

`endif

// ===== src/wait_counter.v
/*
 * loadable down-counter for sequencer waits.
 * assumes load and value come from logic on the same clock.
 */
`default_nettype none
module wait_counter (
    input wire mclk,
    input wire reset_n,
    input wire load,
    input wire [15:0] value,
    output wire done
);
    reg [15:0] count_r; // cycles still to wait

    // counts down to zero and stays there
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            count_r <= 16'h0000;
        end else if (load) begin
            count_r <= value;
        end else if (count_r != 16'h0000) begin
            count_r <= count_r - 16'h0001;
        end
    end

    assign done = (count_r == 16'h0000) && !load;
endmodule // wait_counter
`default_nettype wire

// ===== verification/dll_switch_props.sv
/* port checker for dll_switch_seq.
   assumes bind onto the sequencer, one clock. */
`default_nettype none
module dll_switch_props (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic start,
    input wire logic freq_req,
    input wire logic busy,
    input wire logic done,
    input wire logic cke,
    input wire logic odt,
    input wire logic [3:0] cmd
);
    timeunit 1ns;
    timeprecision 1ps;
    // cycles since the last mode write, saturating
    logic [4:0] gap_r;
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) gap_r <= 5'h1f;
        else if (cmd == 4'h0) gap_r <= 5'h01;
        else if (gap_r != 5'h1f) gap_r <= gap_r + 5'h01;
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (!reset_n);
    start_taken_a: assert property (start && !busy |=> busy)
        else $error("idle start not taken");
    cke_drop_a: assert property ($fell(cke) |-> cmd == 4'h1)
        else $error("cke fell outside sr entry");
    sre_wait_a: assert property (cmd == 4'h1 |-> gap_r >= 5'h0c)
        else $error("sr entry before tmod");
    freq_in_sr_a: assert property ($rose(freq_req) |-> !cke && !$past(cke, 5))
        else $error("clock change outside sr");
    odt_low_a: assert property (busy |-> !odt)
        else $error("odt high while switching");
    mrs_gap_a: assert property (cmd == 4'h0 |=> (cmd != 4'h0)[*3])
        else $error("mode writes too close");
    exit_quiet_a: assert property ($rose(cke) |-> (cmd == 4'h7)[*8] ##1 (cmd == 4'h7)[*8])
        else $error("command before txs");
    done_wait_a: assert property (done |-> gap_r >= 5'h0c && cke)
        else $error("ready before tmod");
    zq_wait_a: assert property (cmd == 4'h6 |-> gap_r >= 5'h0c)
        else $error("zq long before tmod");
    cover property (done);
    cover property (cmd == 4'h6);
    cover property ($rose(freq_req));
endmodule // dll_switch_props
bind dll_switch_seq dll_switch_props chk (.mclk(mclk), .reset_n(reset_n), .start(start),
    .freq_req(freq_req), .busy(busy), .done(done), .cke(cke), .odt(odt), .cmd(cmd));
`default_nettype wire

// ===== verification/dram_dev_model.sv
/* behavioural dram seen through its command pins.
   assumes commands change just after mclk rises. */
`default_nettype none
module dram_dev_model (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic cke,
    input wire logic [3:0] cmd,
    input wire logic [2:0] ba,
    input wire logic [13:0] addr,
    output logic dll_off,
    output logic in_sr,
    output logic zq_seen,
    output logic [13:0] mr0_seen,
    output logic [13:0] mr2_seen,
    output logic [10:0] lock_cnt
);
    timeunit 1ns;
    timeprecision 1ps;
    // mode writes only count outside self refresh
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            dll_off <= 1'b0;
            in_sr <= 1'b0;
            zq_seen <= 1'b0;
            mr0_seen <= 14'h0000;
            mr2_seen <= 14'h0000;
            lock_cnt <= 11'h7ff;
        end else begin
            if (lock_cnt != 11'h7ff) lock_cnt <= lock_cnt + 11'h001;
            if (!cke && cmd == 4'h1) in_sr <= 1'b1;
            if (in_sr && cke) in_sr <= 1'b0;
            if (cmd == 4'h6) zq_seen <= 1'b1;
            // a mode write is taken whenever cke is high outside sr; waits are not checked
            if (cke && !in_sr && cmd == 4'h0) begin
                if (ba == 3'h1) dll_off <= addr[0];
                if (ba == 3'h0) mr0_seen <= addr;
                if (ba == 3'h2) mr2_seen <= addr;
                if (ba == 3'h0 && addr[8]) lock_cnt <= 11'h000;
            end
        end
    end
endmodule // dram_dev_model
`default_nettype wire

// ===== verification/ddr3_dll_mode_switch_sequencer_bench.sv
/* self-checking bench for the dll switch sequencer.
   assumes the dram model and the bound checker. */
`default_nettype none
module ddr3_dll_mode_switch_sequencer_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk = 1'b0;
    logic reset_n = 1'b0;
    logic start = 1'b0;
    logic to_dll_off = 1'b0;
    logic zq_long_en = 1'b0;
    logic freq_ack = 1'b0;
    logic freq_req, busy, done, cke, odt, dll_off, in_sr, zq_seen;
    logic [3:0] cmd;
    logic [2:0] ba;
    logic [13:0] addr, mr0_seen, mr2_seen;
    logic [10:0] lock_cnt;
    int bad_count = 0;
    int samples_checked = 0;
    int cycles = 0;
    always #5 mclk = ~mclk;
    // clock source stand-in: stable one edge after the request
    always @(posedge mclk) freq_ack <= #1 freq_req;
    dll_switch_seq dut (.mclk(mclk), .reset_n(reset_n), .start(start),
        .to_dll_off(to_dll_off), .zq_long_en(zq_long_en), .mr0_value(14'h0010),
        .mr1_value(14'h0000), .mr2_value(14'h0018), .freq_ack(freq_ack),
        .freq_req(freq_req), .busy(busy), .done(done), .cke(cke), .odt(odt),
        .cmd(cmd), .ba(ba), .addr(addr));
    dram_dev_model dram (.mclk(mclk), .reset_n(reset_n), .cke(cke), .cmd(cmd),
        .ba(ba), .addr(addr), .dll_off(dll_off), .in_sr(in_sr), .zq_seen(zq_seen),
        .mr0_seen(mr0_seen), .mr2_seen(mr2_seen), .lock_cnt(lock_cnt));
    task automatic check(input string what, input logic [13:0] exp, input logic [13:0] got);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // one switch; poke retries start mid-run with the other direction
    task automatic switch_once(input logic off, input logic zq, input logic poke);
        int n = 0;
        to_dll_off = off;
        zq_long_en = zq;
        start = 1'b1;
        @(posedge mclk) #1;
        start = 1'b0;
        to_dll_off = ~off;
        while (done !== 1'b1 && n < 5000) begin
            @(posedge mclk) #1;
            start = poke && n == 20;
            n++;
        end
        check("done", 14'h0001, {13'h0, done});
        check("cke", 14'h0001, {13'h0, cke});
        check("odt", 14'h0000, {13'h0, odt});
    endtask
    task automatic to_off();
        switch_once(1'b1, 1'b0, 1'b0);
        check("dll off", 14'h0001, {13'h0, dll_off});
        check("cl field", 14'h0020, mr0_seen & 14'h0074);
        check("cwl field", 14'h0008, mr2_seen & 14'h0038);
        check("no zq", 14'h0000, {13'h0, zq_seen});
    endtask
    task automatic to_on();
        switch_once(1'b0, 1'b1, 1'b1);
        check("dll on", 14'h0000, {13'h0, dll_off});
        check("lock wait", 14'h0001, {13'h0, lock_cnt >= 11'h200});
        check("mr0 restored", 14'h0010, mr0_seen);
        check("mr2 restored", 14'h0018, mr2_seen);
        check("zq issued", 14'h0001, {13'h0, zq_seen});
        repeat (3) @(posedge mclk);
        check("busy refused", 14'h0000, {13'h0, busy});
    endtask
    // hang guard
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            complete_run();
        end
    end
    initial begin
        repeat (6) @(posedge mclk);
        #1 reset_n = 1'b1;
        @(posedge mclk) #1;
        to_off();
        @(posedge mclk) #1;
        to_on();
        complete_run();
    end
endmodule // ddr3_dll_mode_switch_sequencer_bench
`default_nettype wire
